// [lpt_test_ctrl.v]
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`include "lpt_map.vh"
module lpt_test_ctrl #(
    parameter [39:0] PAT_TIMEOUT_CYC = `LPT_PAT_TIMEOUT_S * `LPT_CLK_HZ,
    parameter [39:0] RST_DATA_CYC = `LPT_RST_DATA_S * `LPT_CLK_HZ,
    parameter [39:0] RST_LONG_CYC = `LPT_RST_LONG_S * `LPT_CLK_HZ,
    parameter [39:0] RST_START_CYC = `LPT_RST_START_S * `LPT_CLK_HZ,
    parameter [39:0] BLINK_CYC = `LPT_BLINK_MS * `LPT_CLK_HZ / `LPT_MS_PER_S,
    parameter [39:0] FLASH_CYC = `LPT_FLASH_MS * `LPT_CLK_HZ / `LPT_MS_PER_S
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire dte_llb_i,
    input wire dte_rdl_i,
    input wire frame_ok_i,
    input wire bit_tick_i,
    input wire dte_td_i,
    input wire line_rd_i,
    output reg line_td_o,
    output reg dte_rd_o,
    output reg dte_rd_valid_o,
    output reg [1:0] eoc_tx_cmd_o,
    output reg eoc_tx_valid_o,
    input wire eoc_tx_ready_i,
    input wire eoc_tx_done_i,
    input wire [1:0] eoc_rx_cmd_i,
    input wire eoc_rx_valid_i,
    output reg restart_o,
    output reg error_indicator_o,
    output reg test_mode_indicator_o,
    output reg no_signal_indicator_o
);

    localparam [2:0] RDL_IDLE = 3'h0;
    localparam [2:0] REMOTE_LOOP_ON_REQUEST_TX = 3'h1;
    localparam [2:0] RDL_WAIT_ACK = 3'h2;
    localparam [2:0] RDL_ACTIVE = 3'h3;
    localparam [2:0] REMOTE_LOOP_OFF_REQUEST_TX = 3'h4;
    localparam [2:0] REMOTE_LOOP_OFF_REQUEST_WAIT = 3'h5;
    localparam [2:0] RDL_LOCKOUT = 3'h6;

    function prbs_fb;
        input [8:0] sh;
        begin
            prbs_fb = sh[8] ^ sh[4];
        end
    endfunction

    reg [3:0] ctrl_q;
    reg [15:0] errcnt_q;
    reg [1:0] llb_sync_q;
    reg [1:0] rdl_sync_q;
    reg linked_q;
    reg loop_q;
    reg loop_m2_q;
    reg llb_prev_q;
    reg remote_q;
    reg ack_pend_q;
    reg [2:0] rdl_state_q;
    reg rethrown_q;
    reg pat_run_q;
    reg pat_tmo_q;
    reg pat_sw_prev_q;
    reg [39:0] pat_cnt_q;
    reg [39:0] rst_cnt_q;
    reg [39:0] blink_cnt_q;
    reg [39:0] flash_cnt_q;
    reg blink_q;
    reg [8:0] gen_q;
    reg [8:0] inj_cnt_q;
    reg [8:0] det_q;
    reg [3:0] sync_cnt_q;
    reg det_err_q;

    wire llb_req = ctrl_q[`LPT_CTRL_LLB] | llb_sync_q[1];
    wire rdl_req = ctrl_q[`LPT_CTRL_RDL] | rdl_sync_q[1];
    wire pat_sw = ctrl_q[`LPT_CTRL_PAT_EN];
    wire pat_inj = ctrl_q[`LPT_CTRL_PAT_INJ];
    wire pat_allowed = ~(loop_q & loop_m2_q) & ~remote_q;
    wire rdl_up = (rdl_state_q == RDL_ACTIVE);
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i;
    wire rx_on = eoc_rx_valid_i & (eoc_rx_cmd_i == `LPT_CMD_ON);
    wire rx_off = eoc_rx_valid_i & (eoc_rx_cmd_i == `LPT_CMD_OFF);
    wire rx_ack = eoc_rx_valid_i & (eoc_rx_cmd_i == `LPT_CMD_ACK);
    wire tx_take = eoc_tx_valid_o & eoc_tx_ready_i;
    wire gen_bit = prbs_fb(gen_q);
    wire inj_now = pat_inj & (inj_cnt_q == `LPT_INJ_PERIOD);
    wire tx_pat_bit = gen_bit ^ inj_now;
    // Mode 1 loop keeps the pattern inside; otherwise it comes back off the line
    wire det_in = (loop_q & ~loop_m2_q) ? tx_pat_bit : line_rd_i;
    wire det_mis = det_in ^ prbs_fb(det_q);
    wire det_synced = (sync_cnt_q == `LPT_SYNC_BITS);

    reg [39:0] rst_limit;
    reg [31:0] rd_data;

    // Restart limit for consecutive unframed time
    always @* begin
        if (remote_q) begin
            rst_limit = RST_LONG_CYC;
        end else if (pat_run_q) begin
            rst_limit = RST_LONG_CYC;
        end else if (linked_q) begin
            rst_limit = RST_DATA_CYC;
        end else begin
            rst_limit = RST_START_CYC;
        end
    end

    always @* begin
        case (wb_adr_i)
            `LPT_REG_CTRL: rd_data = {28'h0000000, ctrl_q};
            `LPT_REG_STATUS: rd_data = {21'h000000, rdl_state_q, det_synced, pat_tmo_q, pat_run_q,
                                        rdl_up, remote_q, loop_m2_q, loop_q, linked_q};
            `LPT_REG_ERRCNT: rd_data = {16'h0000, errcnt_q};
            default: rd_data = 32'h00000000;
        endcase
    end

    // Register bus
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl_q <= `LPT_CTRL_RESET;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_data : 32'h00000000;
            if (wb_wr && wb_adr_i == `LPT_REG_CTRL && wb_sel_i[0]) begin
                ctrl_q <= wb_dat_i[3:0];
            end
        end
    end

    // Pin synchronisers
    always @(posedge clk_i) begin
        if (rst_i) begin
            llb_sync_q <= 2'h0;
            rdl_sync_q <= 2'h0;
        end else begin
            llb_sync_q <= {llb_sync_q[0], dte_llb_i};
            rdl_sync_q <= {rdl_sync_q[0], dte_rdl_i};
        end
    end

    // Link state and restart timer
    always @(posedge clk_i) begin
        if (rst_i) begin
            linked_q <= 1'b0;
            rst_cnt_q <= 40'h0000000000;
            restart_o <= 1'b0;
        end else begin
            restart_o <= 1'b0;
            if (frame_ok_i) begin
                rst_cnt_q <= 40'h0000000000;
                linked_q <= 1'b1;
            end else if (rst_cnt_q + 40'h0000000001 >= rst_limit) begin
                rst_cnt_q <= 40'h0000000000;
                linked_q <= 1'b0;
                restart_o <= 1'b1;
            end else begin
                rst_cnt_q <= rst_cnt_q + 40'h0000000001;
            end
        end
    end

    // Local loop
    always @(posedge clk_i) begin
        if (rst_i) begin
            loop_q <= 1'b0;
            loop_m2_q <= 1'b0;
            llb_prev_q <= 1'b0;
        end else begin
            llb_prev_q <= llb_req;
            if (llb_req && !llb_prev_q) begin
                loop_q <= 1'b1;
                loop_m2_q <= linked_q;
            end else if (!llb_req) begin
                loop_q <= 1'b0;
                loop_m2_q <= 1'b0;
            end
        end
    end

    // Remote loop, local side and far-end side
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdl_state_q <= RDL_IDLE;
            rethrown_q <= 1'b0;
            remote_q <= 1'b0;
            ack_pend_q <= 1'b0;
            eoc_tx_valid_o <= 1'b0;
            eoc_tx_cmd_o <= `LPT_CMD_NONE;
        end else begin
            if (tx_take) begin
                eoc_tx_valid_o <= 1'b0;
                eoc_tx_cmd_o <= `LPT_CMD_NONE;
            end
            // Far end of a remote loop
            if (rx_on && rdl_state_q == RDL_IDLE) begin
                remote_q <= 1'b1;
                ack_pend_q <= 1'b1;
            end else if (rx_off || restart_o) begin
                remote_q <= 1'b0;
            end
            if (ack_pend_q && (!eoc_tx_valid_o || tx_take)) begin
                eoc_tx_valid_o <= 1'b1;
                eoc_tx_cmd_o <= `LPT_CMD_ACK;
                ack_pend_q <= 1'b0;
            end
            case (rdl_state_q)
                RDL_IDLE: begin
                    if (rdl_req && !remote_q && !ack_pend_q && !eoc_tx_valid_o) begin
                        eoc_tx_valid_o <= 1'b1;
                        eoc_tx_cmd_o <= `LPT_CMD_ON;
                        rdl_state_q <= REMOTE_LOOP_ON_REQUEST_TX;
                    end
                end
                REMOTE_LOOP_ON_REQUEST_TX: begin
                    if (tx_take) begin
                        rdl_state_q <= RDL_WAIT_ACK;
                    end
                end
                RDL_WAIT_ACK: begin
                    if (rx_ack) begin
                        rdl_state_q <= RDL_ACTIVE;
                    end else if (!rdl_req) begin
                        rdl_state_q <= REMOTE_LOOP_OFF_REQUEST_TX;
                    end
                end
                RDL_ACTIVE: begin
                    if (restart_o) begin
                        rdl_state_q <= RDL_IDLE;
                    end else if (!rdl_req) begin
                        rdl_state_q <= REMOTE_LOOP_OFF_REQUEST_TX;
                    end
                end
                REMOTE_LOOP_OFF_REQUEST_TX: begin
                    if (rdl_req) begin
                        rethrown_q <= 1'b1;
                    end
                    if (!eoc_tx_valid_o && !ack_pend_q) begin
                        eoc_tx_valid_o <= 1'b1;
                        eoc_tx_cmd_o <= `LPT_CMD_OFF;
                        rdl_state_q <= REMOTE_LOOP_OFF_REQUEST_WAIT;
                    end
                end
                REMOTE_LOOP_OFF_REQUEST_WAIT: begin
                    if (rdl_req) begin
                        rethrown_q <= 1'b1;
                    end
                    // Held until the request has left the channel in full
                    if (eoc_tx_done_i && !eoc_tx_valid_o) begin
                        rdl_state_q <= (rethrown_q || rdl_req) ? RDL_LOCKOUT : RDL_IDLE;
                        rethrown_q <= 1'b0;
                    end
                end
                RDL_LOCKOUT: begin
                    if (!rdl_req) begin
                        rdl_state_q <= RDL_IDLE;
                    end
                end
                default: begin
                    rdl_state_q <= RDL_IDLE;
                end
            endcase
        end
    end

    // Pattern run, timeout and sticky timeout flag
    always @(posedge clk_i) begin
        if (rst_i) begin
            pat_run_q <= 1'b0;
            pat_tmo_q <= 1'b0;
            pat_sw_prev_q <= 1'b0;
            pat_cnt_q <= 40'h0000000000;
        end else begin
            pat_sw_prev_q <= pat_sw;
            if (!pat_sw) begin
                pat_run_q <= 1'b0;
                pat_tmo_q <= 1'b0;
                pat_cnt_q <= 40'h0000000000;
            end else if (pat_sw && !pat_sw_prev_q && pat_allowed) begin
                pat_run_q <= 1'b1;
                pat_cnt_q <= 40'h0000000000;
            end else if (pat_run_q) begin
                if (!pat_allowed) begin
                    pat_run_q <= 1'b0;
                end else if (pat_cnt_q + 40'h0000000001 >= PAT_TIMEOUT_CYC) begin
                    pat_run_q <= 1'b0;
                    pat_tmo_q <= 1'b1;
                end else begin
                    pat_cnt_q <= pat_cnt_q + 40'h0000000001;
                end
            end
        end
    end

    // Generator and detector, one step per line bit
    always @(posedge clk_i) begin
        if (rst_i || !pat_run_q) begin
            gen_q <= `LPT_PRBS_SEED;
            inj_cnt_q <= 9'h000;
            det_q <= 9'h000;
            sync_cnt_q <= 4'h0;
            det_err_q <= 1'b0;
        end else begin
            det_err_q <= 1'b0;
            if (bit_tick_i) begin
                gen_q <= {gen_q[7:0], gen_bit};
                inj_cnt_q <= inj_now ? 9'h000 : inj_cnt_q + 9'h001;
                det_q <= {det_q[7:0], det_in};
                // Errors count only once nine clean bits filled the register
                if (!det_synced) begin
                    sync_cnt_q <= det_mis ? 4'h0 : sync_cnt_q + 4'h1;
                end else if (det_mis) begin
                    det_err_q <= 1'b1;
                end
            end
        end
    end

    // Error count, cleared by a write to its offset unless an error is counted in that same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            errcnt_q <= 16'h0000;
        end else if (det_err_q && errcnt_q != 16'hFFFF) begin
            errcnt_q <= errcnt_q + 16'h0001;
        end else if (wb_wr && wb_adr_i == `LPT_REG_ERRCNT) begin
            errcnt_q <= 16'h0000;
        end
    end

    // Data path steering
    always @(posedge clk_i) begin
        if (rst_i) begin
            line_td_o <= 1'b1;
            dte_rd_o <= 1'b1;
            dte_rd_valid_o <= 1'b0;
        end else if (remote_q) begin
            line_td_o <= line_rd_i;
            dte_rd_o <= line_rd_i;
            dte_rd_valid_o <= 1'b1;
        end else if (pat_run_q && loop_q && !loop_m2_q) begin
            line_td_o <= 1'b1;
            dte_rd_o <= 1'b1;
            dte_rd_valid_o <= 1'b0;
        end else if (pat_run_q) begin
            line_td_o <= tx_pat_bit;
            dte_rd_o <= 1'b1;
            dte_rd_valid_o <= 1'b0;
        end else if (loop_q) begin
            line_td_o <= loop_m2_q ? line_rd_i : 1'b1;
            dte_rd_o <= dte_td_i;
            dte_rd_valid_o <= 1'b1;
        end else begin
            line_td_o <= dte_td_i;
            dte_rd_o <= line_rd_i;
            dte_rd_valid_o <= linked_q;
        end
    end

    // Indicators
    always @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt_q <= 40'h0000000000;
            blink_q <= 1'b0;
            flash_cnt_q <= 40'h0000000000;
            error_indicator_o <= 1'b0;
            test_mode_indicator_o <= 1'b0;
            no_signal_indicator_o <= 1'b1;
        end else begin
            if (blink_cnt_q + 40'h0000000001 >= BLINK_CYC) begin
                blink_cnt_q <= 40'h0000000000;
                blink_q <= ~blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 40'h0000000001;
            end
            // Stretch so single bit errors are visible
            if (det_err_q) begin
                flash_cnt_q <= FLASH_CYC;
            end else if (flash_cnt_q != 40'h0000000000) begin
                flash_cnt_q <= flash_cnt_q - 40'h0000000001;
            end
            error_indicator_o <= pat_tmo_q ? blink_q : (flash_cnt_q != 40'h0000000000);
            test_mode_indicator_o <= loop_q | remote_q | pat_run_q | (rdl_state_q != RDL_IDLE
                                     && rdl_state_q != RDL_LOCKOUT);
            no_signal_indicator_o <= ~linked_q;
        end
    end

endmodule // lpt_test_ctrl

// [lpt_map.vh]
`ifndef LPT_MAP_VH
`define LPT_MAP_VH

// Register byte offsets
`define LPT_REG_CTRL 8'h00
`define LPT_REG_STATUS 8'h04
`define LPT_REG_ERRCNT 8'h08

// Control fields
`define LPT_CTRL_PAT_EN 0
`define LPT_CTRL_PAT_INJ 1
`define LPT_CTRL_LLB 2
`define LPT_CTRL_RDL 3
`define LPT_CTRL_RESET 4'h0

// Status fields
`define LPT_ST_LINKED 0
`define LPT_ST_LOOP 1
`define LPT_ST_LOOP_M2 2
`define LPT_ST_REMOTE 3
`define LPT_ST_RDL_UP 4
`define LPT_ST_PAT_RUN 5
`define LPT_ST_PAT_TMO 6
`define LPT_ST_SYNC 7
`define LPT_ST_RDL_STATE 8

// Out-of-band channel commands
`define LPT_CMD_NONE 2'h0
`define LPT_CMD_ON 2'h1
`define LPT_CMD_OFF 2'h2
`define LPT_CMD_ACK 2'h3

// Timing
`define LPT_CLK_HZ 40'd200000000
`define LPT_PAT_TIMEOUT_S 40'd45
`define LPT_RST_DATA_S 40'd4
`define LPT_RST_LONG_S 40'd60
`define LPT_RST_START_S 40'd50
`define LPT_BLINK_MS 40'd250
`define LPT_FLASH_MS 40'd50
`define LPT_MS_PER_S 40'd1000

// Pattern
`define LPT_PRBS_SEED 9'h1FF
`define LPT_INJ_PERIOD 9'h1FF
`define LPT_SYNC_BITS 4'h9

`endif

// [lpt_test_ctrl_properties.sv]
`timescale 1ns/100ps
`include "lpt_map.vh"
module lpt_test_ctrl_chk (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [31:0] wb_dat_o,
    input wire frame_ok_i,
    input wire restart_o,
    input wire no_signal_indicator_o,
    input wire test_mode_indicator_o,
    input wire eoc_tx_valid_o,
    input wire eoc_tx_ready_i,
    input wire [1:0] eoc_tx_cmd_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_eoc_cmd_held: assert property (
        eoc_tx_valid_o && !eoc_tx_ready_i |=> eoc_tx_valid_o && $stable(eoc_tx_cmd_o))
        else $error("command dropped before taken");
    a_eoc_cmd_legal: assert property (eoc_tx_valid_o |-> eoc_tx_cmd_o != `LPT_CMD_NONE)
        else $error("empty command offered");
    a_tm_during_off: assert property (
        eoc_tx_valid_o && eoc_tx_cmd_o == `LPT_CMD_OFF |-> test_mode_indicator_o)
        else $error("test mode low while off pending");
    a_restart_pulse: assert property (restart_o |=> !restart_o)
        else $error("restart longer than one cycle");
    a_restart_framed: assert property (frame_ok_i [*3] |-> !restart_o)
        else $error("restart while framed");
    a_restart_nosig: assert property (restart_o |-> ##[0:2] no_signal_indicator_o)
        else $error("no signal not shown after restart");
endmodule // lpt_test_ctrl_chk
bind lpt_test_ctrl lpt_test_ctrl_chk u_lpt_test_ctrl_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .frame_ok_i(frame_ok_i),
    .restart_o(restart_o),
    .no_signal_indicator_o(no_signal_indicator_o),
    .test_mode_indicator_o(test_mode_indicator_o),
    .eoc_tx_valid_o(eoc_tx_valid_o),
    .eoc_tx_ready_i(eoc_tx_ready_i),
    .eoc_tx_cmd_o(eoc_tx_cmd_o)
);

// [lpt_remote_model.sv]
`timescale 1ns/100ps
`include "lpt_map.vh"
module lpt_remote_model #(
    parameter LAT = 6
) (
    input wire clk_i,
    input wire [1:0] eoc_tx_cmd_i,
    input wire eoc_tx_valid_i,
    input wire far_i,
    output reg eoc_tx_ready_o = 1'b0,
    output reg eoc_tx_done_o = 1'b0,
    output reg [1:0] eoc_rx_cmd_o = 2'h0,
    output reg eoc_rx_valid_o = 1'b0,
    input wire line_td_i,
    output reg line_rd_o = 1'b1
);
    integer cnt = 0;
    reg [1:0] held = 2'h0;
    reg busy = 1'b0;
    reg far_q = 1'b0;
    always @(posedge clk_i) begin
        eoc_tx_done_o <= 1'b0;
        eoc_rx_valid_o <= 1'b0;
        // Idle command lines wander so stale values never look valid
        eoc_rx_cmd_o <= eoc_rx_cmd_o + 2'h1;
        line_rd_o <= line_td_i;
        cnt <= cnt + 1;
        if (eoc_tx_ready_o && eoc_tx_valid_i) begin
            eoc_tx_ready_o <= 1'b0;
            held <= eoc_tx_cmd_i;
            busy <= 1'b1;
            cnt <= 0;
        end else if (busy) begin
            if (cnt == LAT) eoc_tx_done_o <= 1'b1;
            if (cnt == 2 * LAT) begin
                busy <= 1'b0;
                eoc_rx_valid_o <= (held == `LPT_CMD_ON);
                eoc_rx_cmd_o <= `LPT_CMD_ACK;
            end
        end else if (eoc_tx_valid_i) eoc_tx_ready_o <= 1'b1;
        // Far unit asks to enter or leave a loop at its end
        far_q <= far_i;
        if (far_i != far_q) begin
            eoc_rx_valid_o <= 1'b1;
            eoc_rx_cmd_o <= far_i ? `LPT_CMD_ON : `LPT_CMD_OFF;
        end
    end
endmodule // lpt_remote_model

// [tb.sv]
`timescale 1ns/100ps
`include "lpt_map.vh"
module tb;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [31:0] wdat = 32'h0;
    reg local_loop_request = 1'b0;
    reg remote_digital_loop = 1'b0;
    reg fok = 1'b0;
    reg tick = 1'b0;
    reg td = 1'b0;
    reg td_en = 1'b1;
    reg err_q = 1'b0;
    reg [3:0] sel = 4'hF;
    reg far = 1'b0;
    wire [31:0] rdat;
    wire ack, ltd, drd, drv, txv, txr, txd, rxv, lrd, rst_p, err, tm, ns;
    wire [1:0] txc, rxc;
    integer miscompares = 0;
    integer cmp_count = 0;
    integer n_rst = 0;
    integer n_tog = 0;
    integer n_txv = 0;
    integer cc = 0;
    integer i, n, e0;
    reg [31:0] q;
    reg [72:0] rows [0:9];
    reg [9:0] sh;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        tick <= ~tick;
        if (tick) td <= td_en & ~td;
        cc <= cc + 1;
        err_q <= err;
        if (rst_p) n_rst <= n_rst + 1;
        if (err != err_q) n_tog <= n_tog + 1;
        if (txv) n_txv <= n_txv + 1;
    end
    lpt_test_ctrl #(.PAT_TIMEOUT_CYC(40'd2000), .RST_DATA_CYC(40'd300), .RST_LONG_CYC(40'd3000),
        .RST_START_CYC(40'd1000), .BLINK_CYC(40'd20), .FLASH_CYC(40'd10)) u_lpt_test_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .dte_llb_i(local_loop_request), .dte_rdl_i(remote_digital_loop), .frame_ok_i(fok), .bit_tick_i(tick), .dte_td_i(td),
        .line_rd_i(lrd), .line_td_o(ltd), .dte_rd_o(drd), .dte_rd_valid_o(drv),
        .eoc_tx_cmd_o(txc), .eoc_tx_valid_o(txv), .eoc_tx_ready_i(txr), .eoc_tx_done_i(txd),
        .eoc_rx_cmd_i(rxc), .eoc_rx_valid_i(rxv), .restart_o(rst_p), .error_indicator_o(err),
        .test_mode_indicator_o(tm), .no_signal_indicator_o(ns));
    lpt_remote_model u_lpt_remote_model (.clk_i(clk_i), .eoc_tx_cmd_i(txc), .eoc_tx_valid_i(txv),
        .eoc_tx_ready_o(txr), .eoc_tx_done_o(txd), .eoc_rx_cmd_o(rxc), .eoc_rx_valid_o(rxv),
        .line_td_i(ltd), .line_rd_o(lrd), .far_i(far));
    task wrap_up;
        begin
            $display("compares %0d mismatches %0d", cmp_count, miscompares);
            if (miscompares == 0 && cmp_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task chk_in(input string nm, input integer lo, input integer hi, input integer g);
        begin
            cmp_count = cmp_count + 1;
            if (^g === 1'bx || g < lo || g > hi) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %0s exp %0d..%0d got %0d", nm, lo, hi, g);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d, output [31:0] r);
        integer k;
        begin
            k = 0;
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            @(posedge clk_i);
            while (ack !== 1'b1) begin
                @(posedge clk_i);
                k = k + 1;
            end
            chk("bus ack", 32'h1, k);
            r = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task wait_on(input integer what, output integer c);
        begin
            c = 0;
            while (!(what == 0 ? rst_p === 1'b1 : what == 1 ? (txv & txr) === 1'b1 : txd === 1'b1)
                && c < 5000) begin
                @(posedge clk_i);
                c = c + 1;
            end
        end
    endtask
    initial begin
        rows[0] = {1'b1, `LPT_REG_CTRL, 32'hFFFFFFF4, 32'h0};
        rows[1] = {1'b0, `LPT_REG_CTRL, 32'h0, 32'h4};
        rows[2] = {1'b1, `LPT_REG_CTRL, 32'h0, 32'h0};
        rows[3] = {1'b0, `LPT_REG_CTRL, 32'h0, 32'h0};
        rows[4] = {1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0};
        rows[5] = {1'b0, 8'h0C, 32'h0, 32'h0};
        rows[6] = {1'b1, `LPT_REG_STATUS, 32'hFFFFFFFF, 32'h0};
        rows[7] = {1'b0, `LPT_REG_STATUS, 32'h0, 32'h0};
        rows[8] = {1'b1, `LPT_REG_ERRCNT, 32'h0, 32'h0};
        rows[9] = {1'b0, `LPT_REG_ERRCNT, 32'h0, 32'h0};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("reset outputs", 32'hC1, {24'h0, ltd, drd, drv, txv, rst_p, err, tm, ns});
        for (i = 0; i < 10; i = i + 1) begin
            bus(rows[i][72], rows[i][71:64], rows[i][63:32], q);
            if (!rows[i][72]) chk("register", rows[i][31:0], q);
        end
        sel <= 4'hE;
        bus(1'b1, `LPT_REG_CTRL, 32'hF, q);
        sel <= 4'hF;
        bus(1'b0, `LPT_REG_CTRL, 32'h0, q);
        chk("lane zero off", 32'h0, q);
        fok <= 1'b1;
        repeat (10) @(posedge clk_i);
        bus(1'b0, `LPT_REG_STATUS, 32'h0, q);
        chk("linked", 32'h1, q);
        fok <= 1'b0;
        wait_on(0, n);
        chk_in("data restart", 295, 305, n);
        repeat (3) @(posedge clk_i);
        chk("no signal", 32'h1, {31'h0, ns});
        fok <= 1'b1;
        repeat (5) @(posedge clk_i);
        local_loop_request <= 1'b1;
        repeat (5) @(posedge clk_i);
        bus(1'b1, `LPT_REG_CTRL, 32'h1, q);
        repeat (5) @(posedge clk_i);
        bus(1'b0, `LPT_REG_STATUS, 32'h0, q);
        chk("mode two", 32'h07, {24'h0, q[7:0]});
        bus(1'b1, `LPT_REG_CTRL, 32'h0, q);
        local_loop_request <= 1'b0;
        repeat (5) @(posedge clk_i);
        bus(1'b1, `LPT_REG_CTRL, 32'h1, q);
        e0 = cc;
        sh = 10'h0;
        for (i = 0; i < 60; i = i + 1) begin
            repeat (2) @(posedge clk_i);
            sh = {sh[8:0], ltd};
            if (i > 14) chk("line prbs", {31'h0, sh[9] ^ sh[5]}, {31'h0, sh[0]});
        end
        // Far end unframed for longer than the data-mode limit
        fok <= 1'b0;
        n = n_rst;
        repeat (1000) @(posedge clk_i);
        fok <= 1'b1;
        chk("long timer", n, n_rst);
        q = 32'h0;
        while (!q[6] && cc - e0 < 2600) bus(1'b0, `LPT_REG_STATUS, 32'h0, q);
        chk_in("pattern timeout", 1995, 2015, cc - e0);
        td_en <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk("framed path", 32'h0, {31'h0, ltd});
        chk("dte path", 32'h0, {31'h0, drd});
        td_en <= 1'b1;
        e0 = n_tog;
        repeat (100) @(posedge clk_i);
        chk_in("timeout blink", 4, 6, n_tog - e0);
        bus(1'b1, `LPT_REG_CTRL, 32'h0, q);
        repeat (30) @(posedge clk_i);
        e0 = n_tog;
        repeat (100) @(posedge clk_i);
        chk("blink stopped", e0, n_tog);
        fok <= 1'b0;
        wait_on(0, n);
        local_loop_request <= 1'b1;
        repeat (5) @(posedge clk_i);
        bus(1'b1, `LPT_REG_CTRL, 32'h1, q);
        repeat (100) @(posedge clk_i);
        chk("dte valid", 32'h0, {31'h0, drv});
        bus(1'b0, `LPT_REG_STATUS, 32'h0, q);
        chk("mode one run", 32'hA2, {24'h0, q[7:0]});
        bus(1'b0, `LPT_REG_ERRCNT, 32'h0, q);
        chk("clean errors", 32'h0, q);
        e0 = n_tog;
        bus(1'b1, `LPT_REG_CTRL, 32'h3, q);
        repeat (1200) @(posedge clk_i);
        bus(1'b0, `LPT_REG_ERRCNT, 32'h0, q);
        chk("injected seen", 32'h1, {31'h0, |q[15:0]});
        chk("indicator lit", 32'h1, {31'h0, n_tog > e0});
        bus(1'b1, `LPT_REG_CTRL, 32'h0, q);
        local_loop_request <= 1'b0;
        fok <= 1'b1;
        repeat (10) @(posedge clk_i);
        bus(1'b1, `LPT_REG_CTRL, 32'h8, q);
        wait_on(1, n);
        chk("on request", {30'h0, `LPT_CMD_ON}, {30'h0, txc});
        repeat (40) @(posedge clk_i);
        bus(1'b0, `LPT_REG_STATUS, 32'h0, q);
        chk("loop up", 32'h1, {31'h0, q[4]});
        chk("test mode", 32'h1, {31'h0, tm});
        bus(1'b1, `LPT_REG_CTRL, 32'h9, q);
        repeat (40) @(posedge clk_i);
        bus(1'b0, `LPT_REG_STATUS, 32'h0, q);
        chk("rdl pattern", 32'h3, {30'h0, q[7], q[5]});
        bus(1'b1, `LPT_REG_CTRL, 32'h0, q);
        wait_on(1, n);
        chk("off request", {30'h0, `LPT_CMD_OFF}, {30'h0, txc});
        remote_digital_loop <= 1'b1;
        wait_on(2, n);
        chk("held to done", 32'h1, {31'h0, tm});
        e0 = n_txv;
        repeat (50) @(posedge clk_i);
        bus(1'b0, `LPT_REG_STATUS, 32'h0, q);
        chk("lockout", 32'h6, {29'h0, q[10:8]});
        chk("no resend", e0, n_txv);
        remote_digital_loop <= 1'b0;
        repeat (5) @(posedge clk_i);
        bus(1'b0, `LPT_REG_STATUS, 32'h0, q);
        chk("back idle", 32'h0, {29'h0, q[10:8]});
        chk("test mode off", 32'h0, {31'h0, tm});
        far <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk("remote fwd", {31'h0, ltd}, {31'h0, drd});
        chk("remote valid", 32'h1, {31'h0, drv});
        e0 = ltd;
        repeat (2) @(posedge clk_i);
        chk("dte tx ignored", e0, ltd);
        bus(1'b0, `LPT_REG_STATUS, 32'h0, q);
        chk("remote end", 32'h1, {31'h0, q[3]});
        fok <= 1'b0;
        n = n_rst;
        repeat (1000) @(posedge clk_i);
        fok <= 1'b1;
        chk("remote timer", n, n_rst);
        far <= 1'b0;
        repeat (5) @(posedge clk_i);
        bus(1'b0, `LPT_REG_STATUS, 32'h0, q);
        chk("remote ended", 32'h0, {31'h0, q[3]});
        wrap_up;
    end
    initial begin
        #200000;
        miscompares = miscompares + 1;
        wrap_up;
    end
endmodule // tb
